// ### host_ctrl_model.sv
// Host side model: drives the single control pin in bursts and pauses.
// Assumes the bench calls its tasks; pin changes only on falling clk edges.
`timescale 1ns/100ps
module host_ctrl_model #(
  parameter int LAT_CYC = 24,
  parameter int OFF_CYC = 32,
  parameter int HALF    = 10
) (
  input  wire logic clk,
  output logic      ctrl_pin
);
  initial ctrl_pin = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Pulses of HALF cycles low then HALF cycles high keep a 1 us period
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (HALF) @(negedge clk) ctrl_pin <= 1'b0;
      repeat (HALF) @(negedge clk) ctrl_pin <= 1'b1;
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Burst then pin held high through the latch pause
  task automatic send(input int n);
    burst(n);
    wait_cyc(LAT_CYC + 5);
  endtask

  task automatic go_low();
    @(negedge clk) ctrl_pin <= 1'b0;
    wait_cyc(OFF_CYC + 4);
  endtask
endmodule

// ### led_link_ctrl.sv
// Single-wire pulse counting control of an LED current sink driver.
// Assumes ctrl_pin and dropout_near are synchronous to clk.
//
// What this block does
// - Address and data are told apart only by the burst edge count.
// - Bursts of 1 to 16 edges are data; data registers are 4 bits.
// - Bursts of 17 to 21 edges select addresses 0 to 4.
// - Count is latched only after pin stays high for the latch pause.
// - Later data-only bursts go to the last latched address.
// - After disable address is 0; first data loads both level registers.
// - Address 0 writes one value into both level registers.
// - Address 1 is the main group level, address 2 the sub sink level.
// - Full-scale code 1 is 18mA, 2 is 27mA, 3 is 14mA, 4 low mode.
// - Level code 1 is full scale, steps about 1.8dB, code 16 is off.
// - Code 15 is about 25dB down; codes follow a fixed per-scale table.
// - In low mode upper two bits of code minus one enable main group and sub sink.
// - In low mode lower two bits of code minus one set one common current for both.
// - Both sink groups always share high or low current mode.
// - Pin low past the off timeout puts the device into shutdown.
// - Shutdown clears all data registers and the address to zero.
// - Pump starts in 1.5X near dropout and steps to 2X on more.
// - Low codes 5-8 sub only, 9-12 main only, 13-16 both; four currents.
`timescale 1ns/100ps
module led_link_ctrl
  import led_link_pkg::*;
#(
  parameter int LAT_CYC = LATCH_PAUSE_CYC,
  parameter int OFF_CYC = OFF_TIMEOUT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ctrl_pin,
  input  wire logic [3:0]  dropout_near,
  output logic             enabled,
  output logic [2:0]       cur_addr,
  output level_regs_s      regs,
  output pump_mode_e       pump_mode,
  output sink_drive_s      drive
);

  initial begin
    if (LAT_CYC < 1 || OFF_CYC < 1) begin
      $error("led_link_ctrl: timeouts must be at least one cycle");
    end
  end

  logic             pin_q;
  logic             rise;
  logic             latch_pulse;
  logic             off_pulse;
  logic [EDGE_W-1:0] edge_cnt_q;
  logic             enabled_q;
  logic [2:0]       addr_q;
  level_regs_s      regs_q;
  pump_mode_e       pump_q;
  logic [3:0]       dropout_q;
  sink_drive_s      drive_q;
  sink_drive_s      drive_d;
  logic             is_data;
  logic             is_addr;
  logic [3:0]       data_val;

  ////////////////////////////////////////////////////////////////////////
  // Pin timing

  pin_timer #(
    .LAT_CYC (LAT_CYC),
    .OFF_CYC (OFF_CYC)
  ) u_timer (
    .clk         (clk),
    .rst         (rst),
    .ctrl_pin    (ctrl_pin),
    .pin_q       (pin_q),
    .rise        (rise),
    .latch_pulse (latch_pulse),
    .off_pulse   (off_pulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // Enable and shutdown

  always_ff @(posedge clk) begin
    if (rst || off_pulse) begin
      enabled_q <= 1'b0;
    end else if (rise) begin
      enabled_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst edge counter, saturating past the address range

  always_ff @(posedge clk) begin
    if (rst || off_pulse || latch_pulse) begin
      edge_cnt_q <= '0;
    end else if (rise && edge_cnt_q != EDGE_SAT) begin
      edge_cnt_q <= edge_cnt_q + 1'b1;
    end
  end

  assign is_data  = edge_cnt_q >= DATA_MIN && edge_cnt_q <= DATA_MAX;
  assign is_addr  = edge_cnt_q >= ADDR_BASE && edge_cnt_q <= ADDR_LAST;
  // Sixteen edges store as zero, the no-current code of the level registers
  assign data_val = edge_cnt_q[3:0];

  ////////////////////////////////////////////////////////////////////////
  // Address register

  always_ff @(posedge clk) begin
    if (rst || off_pulse) begin
      addr_q <= ADDR_RESET;
    end else if (latch_pulse && is_addr) begin
      addr_q <= 3'(edge_cnt_q - ADDR_BASE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data registers

  always_ff @(posedge clk) begin
    if (rst || off_pulse) begin
      regs_q <= '{REG_RESET, REG_RESET, REG_RESET, REG_RESET};
    end else if (latch_pulse && is_data) begin
      unique case (addr_q)
        ADDR_BOTH: begin
          regs_q.main_group_level  <= data_val;
          regs_q.sub_channel_level <= data_val;
        end
        ADDR_MAIN: begin
          regs_q.main_group_level <= data_val;
        end
        ADDR_SUB: begin
          regs_q.sub_channel_level <= data_val;
        end
        ADDR_SCALE: begin
          regs_q.full_scale_select <= data_val;
        end
        ADDR_LOW: begin
          regs_q.low_level_config <= data_val;
        end
        default: begin
          regs_q <= regs_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pump mode

  always_ff @(posedge clk) begin
    if (rst) begin
      dropout_q <= 4'h0;
    end else begin
      dropout_q <= dropout_near;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !enabled_q) begin
      pump_q <= PUMP_1X;
    end else begin
      unique case (pump_q)
        PUMP_1X: begin
          if (|dropout_near) begin
            pump_q <= PUMP_1P5X;
          end
        end
        PUMP_1P5X: begin
          if (|(dropout_near & ~dropout_q)) begin
            pump_q <= PUMP_2X;
          end
        end
        PUMP_2X: begin
          pump_q <= PUMP_2X;
        end
        default: begin
          pump_q <= PUMP_1X;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sink current decode

  function automatic logic [15:0] level_ua(input logic [3:0] scale,
                                           input logic [3:0] code);
    logic [3:0] idx;
    idx = code - 4'h1;
    unique case (scale)
      SCALE_27MA: level_ua = LVL_27MA_UA[idx];
      SCALE_14MA: level_ua = LVL_14MA_UA[idx];
      default:    level_ua = LVL_18MA_UA[idx];
    endcase
  endfunction

  always_comb begin
    logic [3:0] low_idx;
    low_idx = regs_q.low_level_config - 4'h1;
    drive_d = '0;
    if (enabled_q) begin
      if (regs_q.full_scale_select == SCALE_LOW) begin
        drive_d.low_mode = 1'b1;
        drive_d.main_on  = low_idx[3];
        drive_d.sub_on   = low_idx[2];
        drive_d.main_ua  = low_idx[3] ? LOW_UA[low_idx[1:0]] : 16'h0000;
        drive_d.sub_ua   = low_idx[2] ? LOW_UA[low_idx[1:0]] : 16'h0000;
      end else begin
        drive_d.main_ua  = level_ua(regs_q.full_scale_select,
                                    regs_q.main_group_level);
        drive_d.sub_ua   = level_ua(regs_q.full_scale_select,
                                    regs_q.sub_channel_level);
        drive_d.main_on  = drive_d.main_ua != 16'h0000;
        drive_d.sub_on   = drive_d.sub_ua != 16'h0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_q <= '0;
    end else begin
      drive_q <= drive_d;
    end
  end

  assign enabled   = enabled_q;
  assign cur_addr  = addr_q;
  assign regs      = regs_q;
  assign pump_mode = pump_q;
  assign drive     = drive_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_ADDR_SELECT: assert property (
    latch_pulse && is_addr && !off_pulse |=>
      addr_q == 3'($past(edge_cnt_q) - ADDR_BASE))
    else $error("address not taken from edge count");

  AST_MAIN_WRITE: assert property (
    latch_pulse && is_data && addr_q == ADDR_MAIN && !off_pulse |=>
      regs_q.main_group_level == $past(edge_cnt_q[3:0]) &&
      $stable(regs_q.sub_channel_level))
    else $error("main level write wrong");

  AST_BOTH_WRITE: assert property (
    latch_pulse && is_data && addr_q == ADDR_BOTH && !off_pulse |=>
      regs_q.main_group_level == regs_q.sub_channel_level &&
      regs_q.main_group_level == $past(data_val))
    else $error("address zero did not load both levels");

  AST_DISCARD: assert property (
    latch_pulse && edge_cnt_q >= EDGE_SAT && !off_pulse |=>
      $stable(regs_q) && $stable(addr_q))
    else $error("oversized burst changed state");

  AST_WAIT_LATCH: assert property (
    !latch_pulse && !off_pulse |=> $stable(regs_q) && $stable(addr_q))
    else $error("register changed without latch pause");

  AST_SHUTDOWN: assert property (
    off_pulse |=> regs_q == '0 && addr_q == ADDR_RESET && !enabled_q
      && edge_cnt_q == '0)
    else $error("shutdown did not clear state");

  AST_OFF_TIME: assert property (
    enabled_q && $fell(ctrl_pin) ##1 (!ctrl_pin)[*2] |->
      enabled_q)
    else $error("shutdown too early");

  AST_PUMP_START: assert property (
    enabled_q && pump_q == PUMP_1X && |dropout_near |=>
      pump_q == PUMP_1P5X)
    else $error("pump did not enter 1.5X");

  AST_LOW_COMMON: assert property (
    drive_q.low_mode && drive_q.main_on && drive_q.sub_on |->
      drive_q.main_ua == drive_q.sub_ua)
    else $error("low mode currents differ");

  AST_CODE_OFF: assert property (
    enabled_q && regs_q.main_group_level == 4'h0 &&
      regs_q.full_scale_select != SCALE_LOW |=>
      drive_q.main_ua == 16'h0000 && !drive_q.main_on)
    else $error("code sixteen not off");

  COV_ADDR_THEN_DATA: cover property (
    (latch_pulse && is_addr) ##[1:1000] (latch_pulse && is_data));
  COV_SHUTDOWN: cover property (enabled_q ##1 off_pulse);
  COV_PUMP_2X: cover property (pump_q == PUMP_2X);
  COV_LOW_MODE: cover property (drive_q.low_mode && drive_q.sub_on);

endmodule

// ### led_link_pkg.sv
// Shared constants, lookup tables and carrier types for the single-wire
// LED current control block.
// Assumes a 20 MHz system clock and a control pin synchronous to it.
package led_link_pkg;

  localparam int CLK_MHZ            = 20;
  localparam int LATCH_PAUSE_US     = 500;
  localparam int OFF_TIMEOUT_US     = 500;
  // Longest times: round down to whole cycles
  localparam int LATCH_PAUSE_CYC    = LATCH_PAUSE_US * CLK_MHZ;
  localparam int OFF_TIMEOUT_CYC    = OFF_TIMEOUT_US * CLK_MHZ;
  localparam int TIMER_W            = 15;

  localparam int EDGE_W             = 5;
  localparam logic [4:0] DATA_MIN   = 5'h01;
  localparam logic [4:0] DATA_MAX   = 5'h10;
  localparam logic [4:0] ADDR_BASE  = 5'h11;
  localparam logic [4:0] ADDR_LAST  = 5'h15;
  localparam logic [4:0] EDGE_SAT   = 5'h16;

  // Register addresses
  localparam logic [2:0] ADDR_BOTH  = 3'h0;
  localparam logic [2:0] ADDR_MAIN  = 3'h1;
  localparam logic [2:0] ADDR_SUB   = 3'h2;
  localparam logic [2:0] ADDR_SCALE = 3'h3;
  localparam logic [2:0] ADDR_LOW   = 3'h4;
  localparam logic [2:0] ADDR_RESET = 3'h0;
  localparam logic [3:0] REG_RESET  = 4'h0;

  // Full-scale select codes
  localparam logic [3:0] SCALE_18MA = 4'h1;
  localparam logic [3:0] SCALE_27MA = 4'h2;
  localparam logic [3:0] SCALE_14MA = 4'h3;
  localparam logic [3:0] SCALE_LOW  = 4'h4;

  // Sink current in microamps, indexed by level code minus one
  localparam logic [15:0] LVL_27MA_UA [16] = '{
    16'h6978, 16'h55f0, 16'h4650, 16'h36b0, 16'h2ee0, 16'h2710,
    16'h1f40, 16'h1838, 16'h1450, 16'h10cc, 16'h0ce4, 16'h0b54,
    16'h0960, 16'h076c, 16'h0578, 16'h0000};
  localparam logic [15:0] LVL_18MA_UA [16] = '{
    16'h4650, 16'h3a98, 16'h2ee0, 16'h2710, 16'h1edc, 16'h189c,
    16'h13ec, 16'h1004, 16'h0dac, 16'h0b54, 16'h0898, 16'h076c,
    16'h0640, 16'h0514, 16'h03e8, 16'h0000};
  localparam logic [15:0] LVL_14MA_UA [16] = '{
    16'h36b0, 16'h2af8, 16'h2260, 16'h1bbc, 16'h1770, 16'h12c0,
    16'h0ed8, 16'h0c1c, 16'h0a28, 16'h0834, 16'h06a4, 16'h0578,
    16'h04b0, 16'h03e8, 16'h02bc, 16'h0000};
  localparam logic [15:0] LOW_UA [4] = '{
    16'h0073, 16'h00af, 16'h0118, 16'h0190};

  typedef enum logic [1:0] {
    PUMP_1X,
    PUMP_1P5X,
    PUMP_2X
  } pump_mode_e;

  typedef struct packed {
    logic [3:0] main_group_level;
    logic [3:0] sub_channel_level;
    logic [3:0] full_scale_select;
    logic [3:0] low_level_config;
  } level_regs_s;

  typedef struct packed {
    logic        low_mode;
    logic        main_on;
    logic        sub_on;
    logic [15:0] main_ua;
    logic [15:0] sub_ua;
  } sink_drive_s;

endpackage

// ### pin_timer.sv
// Control pin edge detector and inactivity timer.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/100ps
module pin_timer
  import led_link_pkg::*;
#(
  parameter int LAT_CYC = LATCH_PAUSE_CYC,
  parameter int OFF_CYC = OFF_TIMEOUT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ctrl_pin,
  output logic      pin_q,
  output logic      rise,
  output logic      latch_pulse,
  output logic      off_pulse
);

  localparam logic [TIMER_W-1:0] LAT_T = TIMER_W'(LAT_CYC);
  localparam logic [TIMER_W-1:0] OFF_T = TIMER_W'(OFF_CYC);
  localparam logic [TIMER_W-1:0] T_MAX = {TIMER_W{1'b1}};

  initial begin
    if (LAT_CYC < 1 || OFF_CYC < 1 || LAT_CYC >= 2**TIMER_W - 1 ||
        OFF_CYC >= 2**TIMER_W - 1) begin
      $error("pin_timer: timeout outside counter range");
    end
  end

  logic [TIMER_W-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Pin sample and edge

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= ctrl_pin;
    end
  end

  assign rise = ctrl_pin & ~pin_q;

  ////////////////////////////////////////////////////////////////////////
  // Time since last edge, restarted by either edge

  always_ff @(posedge clk) begin
    if (rst || ctrl_pin != pin_q) begin
      cnt_q <= '0;
    end else if (cnt_q != T_MAX) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign latch_pulse = pin_q && ctrl_pin && cnt_q == LAT_T;
  assign off_pulse   = !pin_q && !ctrl_pin && cnt_q == OFF_T;

endmodule

// ### tb_top.sv
// Self-checking bench for the single-wire LED current control block.
// Assumes host_ctrl_model drives the pin; all inputs change on falling edges.
`timescale 1ns/100ps
module tb_top;
  import led_link_pkg::*;
  localparam int LAT = 24;
  localparam int OFF = 32;
  logic        clk;
  logic        rst;
  logic        ctrl_pin;
  logic [3:0]  dropout_near;
  logic        enabled;
  logic [2:0]  cur_addr;
  level_regs_s regs;
  pump_mode_e  pump_mode;
  sink_drive_s drive;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          low_codes [4] = '{5, 9, 13, 16};

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Host model defaults match LAT and OFF
  host_ctrl_model i_host (
    .clk      (clk),
    .ctrl_pin (ctrl_pin)
  );

  led_link_ctrl #(.LAT_CYC(LAT), .OFF_CYC(OFF)) i_dut (
    .clk          (clk),
    .rst          (rst),
    .ctrl_pin     (ctrl_pin),
    .dropout_near (dropout_near),
    .enabled      (enabled),
    .cur_addr     (cur_addr),
    .regs         (regs),
    .pump_mode    (pump_mode),
    .drive        (drive)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_val(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask

  task automatic chk_regs(input logic [3:0] m, input logic [3:0] s,
                          input logic [3:0] f, input logic [3:0] l);
    chk_val("main_group_level", 16'(m), 16'(regs.main_group_level));
    chk_val("sub_channel_level", 16'(s), 16'(regs.sub_channel_level));
    chk_val("full_scale_select", 16'(f), 16'(regs.full_scale_select));
    chk_val("low_level_config", 16'(l), 16'(regs.low_level_config));
  endtask

  function automatic logic [15:0] exp_ua(input logic [3:0] f,
                                         input logic [3:0] c);
    logic [3:0] idx;
    idx = c - 4'h1;
    case (f)
      SCALE_27MA: return LVL_27MA_UA[idx];
      SCALE_14MA: return LVL_14MA_UA[idx];
      default:    return LVL_18MA_UA[idx];
    endcase
  endfunction

  task automatic chk_drive(input logic [3:0] m, input logic [3:0] s,
                           input logic [3:0] f);
    chk_val("low_mode", 16'h0000, 16'(drive.low_mode));
    chk_val("main_ua", exp_ua(f, m), drive.main_ua);
    chk_val("sub_ua", exp_ua(f, s), drive.sub_ua);
  endtask

  task automatic chk_low(input logic [3:0] c);
    logic [3:0] idx;
    idx = c - 4'h1;
    chk_val("low_mode", 16'h0001, 16'(drive.low_mode));
    chk_val("main_on", 16'(idx[3]), 16'(drive.main_on));
    chk_val("sub_on", 16'(idx[2]), 16'(drive.sub_on));
    if (idx[3]) chk_val("main_ua", LOW_UA[idx[1:0]], drive.main_ua);
    if (idx[2]) chk_val("sub_ua", LOW_UA[idx[1:0]], drive.sub_ua);
  endtask

  task automatic write_reg(input int addr, input int data);
    i_host.send(17 + addr);
    chk_val("cur_addr", 16'(addr), 16'(cur_addr));
    i_host.send(data);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    dropout_near = 4'h0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk_val("enabled", 16'h0000, 16'(enabled));
    chk_regs(4'h0, 4'h0, 4'h0, 4'h0);
    i_host.send(5);
    chk_val("enabled", 16'h0001, 16'(enabled));
    chk_val("cur_addr", 16'h0000, 16'(cur_addr));
    chk_regs(4'h5, 4'h5, 4'h0, 4'h0);
    chk_drive(4'h5, 4'h5, 4'h0);
    i_host.burst(9);
    i_host.wait_cyc(LAT - 10);
    chk_regs(4'h5, 4'h5, 4'h0, 4'h0);
    i_host.wait_cyc(9);
    chk_regs(4'h9, 4'h9, 4'h0, 4'h0);
    write_reg(1, 3);
    chk_regs(4'h3, 4'h9, 4'h0, 4'h0);
    i_host.send(16);
    chk_regs(4'h0, 4'h9, 4'h0, 4'h0);
    chk_drive(4'h0, 4'h9, 4'h0);
    write_reg(2, 15);
    chk_regs(4'h0, 4'hf, 4'h0, 4'h0);
    for (int f = 1; f <= 3; f++) begin
      write_reg(3, f);
      chk_regs(4'h0, 4'hf, 4'(f), 4'h0);
      chk_drive(4'h0, 4'hf, 4'(f));
    end
    i_host.send(22);
    chk_val("cur_addr", 16'h0003, 16'(cur_addr));
    chk_regs(4'h0, 4'hf, 4'h3, 4'h0);
    write_reg(0, 7);
    chk_regs(4'h7, 4'h7, 4'h3, 4'h0);
    write_reg(3, 4);
    foreach (low_codes[k]) begin
      write_reg(4, low_codes[k]);
      chk_regs(4'h7, 4'h7, 4'h4, 4'(low_codes[k]));
      chk_low(4'(low_codes[k]));
    end
    dropout_near = 4'h1;
    i_host.wait_cyc(4);
    chk_val("pump_mode", 16'(PUMP_1P5X), 16'(pump_mode));
    dropout_near = 4'h5;
    i_host.wait_cyc(4);
    chk_val("pump_mode", 16'(PUMP_2X), 16'(pump_mode));
    i_host.go_low();
    chk_val("enabled", 16'h0000, 16'(enabled));
    chk_val("cur_addr", 16'h0000, 16'(cur_addr));
    chk_regs(4'h0, 4'h0, 4'h0, 4'h0);
    chk_val("pump_mode", 16'(PUMP_1X), 16'(pump_mode));
    dropout_near = 4'h0;
    i_host.send(2);
    chk_regs(4'h2, 4'h2, 4'h0, 4'h0);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
